/* File: rtl/gmt_cnt_if.sv */
/*
  Handshake between the totalizer core and one millisecond countdown.
  Assumes both ends share core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface gmt_cnt_if;
  logic start;
  logic tick;
  logic busy;
  logic done;
  modport ctl (output start, output tick, input busy, input done);
  modport cnt (input start, input tick, output busy, output done);
endinterface
`default_nettype wire

/* File: rtl/gmt_countdown.sv */
/*
  Countdown in measurement ticks, restarted by start, one-cycle done pulse.
  Assumes tick is a single-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module gmt_countdown
  import gmt_pkg::*;
#(
  parameter int W = GMT_TMR_W,
  parameter int LOAD = GMT_READOUT_MS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control
  gmt_cnt_if.cnt c
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      c.busy <= 1'b0;
      c.done <= 1'b0;
    end else begin
      c.done <= 1'b0;
      if (c.start) begin
        cnt_r <= W'(LOAD);
        c.busy <= 1'b1;
      end else if (c.busy && c.tick) begin
        cnt_r <= cnt_r - W'(1);
        if (cnt_r == W'(1)) begin
          c.busy <= 1'b0;
          c.done <= 1'b1;
        end
      end
    end
  end
endmodule // gmt_countdown
`default_nettype wire

/* File: rtl/gmt_pkg.sv */
/*
  Constants, register map and types of the gated mass totalizer.
  Assumes a 100 MHz core clock and a word-addressed Avalon-MM slave port.
*/
package gmt_pkg;

  // Timing
  localparam int GMT_CLK_PERIOD_NS = 10;
  localparam int GMT_MEAS_PERIOD_NS = 1_000_000;
  localparam int GMT_MS_CYCLES = GMT_MEAS_PERIOD_NS / GMT_CLK_PERIOD_NS;
  localparam int GMT_READOUT_S = 5;
  localparam int GMT_HOLD_S = 15;
  localparam int GMT_READOUT_MS = GMT_READOUT_S * 1000;
  localparam int GMT_HOLD_MS = GMT_HOLD_S * 1000;
  localparam int GMT_TMR_W = 14;

  // Data widths and values
  localparam int GMT_TOTAL_W = 15;
  localparam logic [14:0] GMT_TOTAL_MAX = 15'h7FFF;
  localparam logic [19:0] GMT_DISP_OVER = 20'hF_423F;
  localparam logic [13:0] GMT_DISP_RATE_RST = 14'h0064;
  localparam logic [13:0] GMT_ANA_RATE_RST = 14'h0001;

  // Register indices; byte address is four times the index
  localparam logic [2:0] GMT_REG_CTRL = 3'h0;
  localparam logic [2:0] GMT_REG_STATUS = 3'h1;
  localparam logic [2:0] GMT_REG_RESULT = 3'h2;
  localparam logic [2:0] GMT_REG_IRQ_STS = 3'h3;
  localparam logic [2:0] GMT_REG_IRQ_MASK = 3'h4;
  localparam logic [2:0] GMT_REG_FLOW = 3'h5;

  // Control fields
  localparam int GMT_CTRL_ANA_LSB = 0;
  localparam int GMT_CTRL_DISP_LSB = 16;
  localparam int GMT_CTRL_UNIT_BIT = 31;

  // Interrupt event bits
  localparam int GMT_EV_START = 0;
  localparam int GMT_EV_STOP = 1;
  localparam int GMT_EV_RANGE = 2;
  localparam int GMT_EV_NORMAL = 3;
  localparam int GMT_EV_W = 4;

  typedef enum logic [1:0] {
    GMT_NORMAL,
    GMT_WINDOW,
    GMT_READOUT
  } gmt_mode_t;

endpackage

/* File: rtl/gmt_tick_gen.sv */
/*
  Free-running divider giving one pulse per measurement period.
  Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module gmt_tick_gen
  import gmt_pkg::*;
#(
  parameter int PERIOD = GMT_MS_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Pulse
  output logic tick_o
);
  logic [31:0] cnt_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else if (cnt_r == 32'(PERIOD - 1)) begin
      cnt_r <= 32'h0000_0000;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick_o <= 1'b0;
    end
  end
endmodule // gmt_tick_gen
`default_nettype wire

/* File: rtl/gmt_totalizer.sv */
/*
  Gated mass totalizer: window control, accumulation, parallel result,
  display and analog update, Avalon-MM register slave and interrupt.
  Assumes remote_gate_i and the sample inputs are synchronous to core_clk_i
  and that the sample inputs are valid at every measurement tick.
*/
//
// Behaviour
// R1: Gate falling edge opens window, starts accumulation
// R2: Gate rising edge closes window, stops accumulation
// R3: Gate-active lamp lit during the window
// R4: Display blanked, measuring rate ignored in window
// R5: Analog output updated every 1 ms tick; outside the window the code updates it only every ana_rate ticks
// R6: Out-of-range sample gives all-ones result, ready
// R7: After out-of-range window show 999999, then normal
// R8: Result and ready held about fifteen seconds
// R9: Back to normal mode five seconds after close
// R10: Partner keeps window between 10 and 115 s
// R11: Total is unsigned 15 bits, max 32767
// R12: Total counted in grams or normal liters
// R13: Result readable on bus and parallel port
// R14: Clear at start, add increment each tick
`timescale 1ns/1ps
`default_nettype none
module gmt_totalizer
  import gmt_pkg::*;
#(
  parameter int MS_CYCLES = GMT_MS_CYCLES,
  parameter int READOUT_MS = GMT_READOUT_MS,
  parameter int HOLD_MS = GMT_HOLD_MS,
  parameter int INC_W = 8,
  parameter int FLOW_W = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Remote gate
  input wire logic remote_gate_i,
  // Flow samples, taken at each measurement tick
  input wire logic [FLOW_W-1:0] sample_flow_i,
  input wire logic [INC_W-1:0] sample_grams_i,
  input wire logic [INC_W-1:0] sample_nliters_i,
  input wire logic sample_over_range_i,
  // Parallel result
  output logic [GMT_TOTAL_W-1:0] par_data_o,
  output logic par_ready_o,
  // Front panel and analog output
  output logic gate_active_lamp_o,
  output logic display_blank_o,
  output logic [19:0] display_value_o,
  output logic [FLOW_W-1:0] analog_value_o,
  // Avalon-MM slave
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Interrupt
  output logic irq_o
);

  gmt_cnt_if readout_if ();
  gmt_cnt_if hold_if ();

  logic tick;
  gmt_mode_t mode_r;
  logic gate_prev_r;
  logic [GMT_TOTAL_W-1:0] total_r;
  logic over_seen_r;
  logic over_shown_r;
  logic [FLOW_W-1:0] flow_r;
  logic [31:0] ctrl_r;
  logic [GMT_EV_W-1:0] irq_sts_r;
  logic [GMT_EV_W-1:0] irq_mask_r;
  logic [13:0] ana_cnt_r;
  logic [13:0] disp_cnt_r;

  logic gate_fall;
  logic gate_rise;
  logic win_start;
  logic win_stop;
  logic in_window;
  logic unit_nl;
  logic [13:0] ana_rate;
  logic [13:0] disp_rate;
  logic [INC_W-1:0] inc;
  logic [GMT_TOTAL_W:0] sum;
  logic bus_req;
  logic bus_take;
  logic bus_wr;
  logic [31:0] wmask;
  logic [31:0] rd_nxt;
  logic [GMT_EV_W-1:0] ev;
  logic [GMT_EV_W-1:0] irq_clr;

  gmt_tick_gen #(
    .PERIOD(MS_CYCLES)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // Readout period decides when normal mode returns
  gmt_countdown #(
    .W(GMT_TMR_W),
    .LOAD(READOUT_MS)
  ) u_readout (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .c(readout_if.cnt)
  );

  // Longer hold of the parallel result, independent of the mode
  gmt_countdown #(
    .W(GMT_TMR_W),
    .LOAD(HOLD_MS)
  ) u_hold (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .c(hold_if.cnt)
  );

  assign readout_if.tick = tick;
  assign hold_if.tick = tick;
  assign readout_if.start = win_stop;
  assign hold_if.start = win_stop;

  assign gate_fall = gate_prev_r & ~remote_gate_i;
  assign gate_rise = ~gate_prev_r & remote_gate_i;
  // A new window may open from normal mode or during the readout
  assign win_start = gate_fall && (mode_r != GMT_WINDOW); // [R1]
  assign win_stop = gate_rise && (mode_r == GMT_WINDOW); // [R2]
  assign in_window = (mode_r == GMT_WINDOW);

  assign unit_nl = ctrl_r[GMT_CTRL_UNIT_BIT];
  assign ana_rate = ctrl_r[GMT_CTRL_ANA_LSB +: 14];
  assign disp_rate = ctrl_r[GMT_CTRL_DISP_LSB +: 14];
  assign inc = unit_nl ? sample_nliters_i : sample_grams_i; // [R12]
  assign sum = {1'b0, total_r} + (GMT_TOTAL_W + 1)'(inc);

  // Gate edge detection; the line is assumed idle high
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gate_prev_r <= 1'b1;
    end else begin
      gate_prev_r <= remote_gate_i;
    end
  end

  // Operating mode
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_r <= GMT_NORMAL;
    end else begin
      case (mode_r)
        GMT_NORMAL: begin
          if (win_start) begin
            mode_r <= GMT_WINDOW; // [R1]
          end
        end
        GMT_WINDOW: begin
          if (win_stop) begin
            mode_r <= GMT_READOUT; // [R2]
          end
        end
        GMT_READOUT: begin
          if (win_start) begin
            mode_r <= GMT_WINDOW;
          end else if (readout_if.done) begin
            mode_r <= GMT_NORMAL; // [R9]
          end
        end
        default: begin
          mode_r <= GMT_NORMAL;
        end
      endcase
    end
  end

  // Accumulation; saturates rather than wrapping so a long window never reads small
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      total_r <= '0;
      over_seen_r <= 1'b0;
    end else if (win_start) begin
      total_r <= '0; // [R14]
      over_seen_r <= 1'b0;
    end else if (in_window && tick && !win_stop) begin
      if (sum > (GMT_TOTAL_W + 1)'(GMT_TOTAL_MAX)) begin
        total_r <= GMT_TOTAL_MAX; // [R11]
      end else begin
        total_r <= sum[GMT_TOTAL_W-1:0]; // [R14]
      end
      if (sample_over_range_i) begin
        over_seen_r <= 1'b1;
      end
    end
  end

  // Parallel result and ready flag
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      par_data_o <= '0;
      par_ready_o <= 1'b0;
    end else if (win_stop) begin
      par_data_o <= over_seen_r ? {GMT_TOTAL_W{1'b1}} : total_r; // [R6] [R13]
      par_ready_o <= 1'b1; // [R8]
    end else if (win_start || hold_if.done) begin
      par_ready_o <= 1'b0; // [R8]
    end
  end

  // Overflow marker stays on the display for the readout period
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      over_shown_r <= 1'b0;
    end else if (win_stop) begin
      over_shown_r <= over_seen_r; // [R7]
    end else if (win_start || readout_if.done) begin
      over_shown_r <= 1'b0;
    end
  end

  // Lamp
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gate_active_lamp_o <= 1'b0;
    end else begin
      gate_active_lamp_o <= (in_window && !win_stop) || win_start; // [R3]
    end
  end

  // Latest flowrate sample
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flow_r <= '0;
    end else if (tick) begin
      flow_r <= sample_flow_i;
    end
  end

  // Analog output: every tick in the window, every N ticks otherwise
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      analog_value_o <= '0;
      ana_cnt_r <= 14'h0000;
    end else if (tick) begin
      if (in_window) begin
        analog_value_o <= sample_flow_i; // [R5]
        ana_cnt_r <= 14'h0000;
      end else if (ana_cnt_r + 14'h0001 >= ana_rate) begin
        analog_value_o <= sample_flow_i;
        ana_cnt_r <= 14'h0000;
      end else begin
        ana_cnt_r <= ana_cnt_r + 14'h0001;
      end
    end
  end

  // Display: blank in the window, result or marker in readout, flow otherwise
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      display_blank_o <= 1'b0;
      display_value_o <= 20'h0_0000;
      disp_cnt_r <= 14'h0000;
    end else begin
      // Same term as the lamp, so blanking never lags the window by a cycle
      display_blank_o <= (in_window && !win_stop) || win_start; // [R4]
      if (in_window) begin
        disp_cnt_r <= 14'h0000; // [R4]
      end else if (mode_r == GMT_READOUT) begin
        display_value_o <= over_shown_r ? GMT_DISP_OVER : 20'(par_data_o); // [R7]
      end else if (tick) begin
        if (disp_cnt_r + 14'h0001 >= disp_rate) begin
          display_value_o <= 20'(sample_flow_i);
          disp_cnt_r <= 14'h0000;
        end else begin
          disp_cnt_r <= disp_cnt_r + 14'h0001;
        end
      end
    end
  end

  // Bus: one wait cycle, then a single cycle with waitrequest low
  assign bus_req = avs_read_i || avs_write_i;
  assign bus_take = bus_req && !avs_waitrequest_o;
  assign bus_wr = bus_take && avs_write_i;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address_i)
      GMT_REG_CTRL: rd_nxt = ctrl_r;
      GMT_REG_STATUS: rd_nxt = {27'h000_0000, gate_active_lamp_o, over_seen_r, par_ready_o,
                                mode_r == GMT_READOUT, in_window};
      GMT_REG_RESULT: rd_nxt = 32'(par_data_o); // [R13]
      GMT_REG_IRQ_STS: rd_nxt = 32'(irq_sts_r);
      GMT_REG_IRQ_MASK: rd_nxt = 32'(irq_mask_r);
      GMT_REG_FLOW: rd_nxt = 32'(flow_r);
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o <= avs_read_i ? rd_nxt : 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Control register; rates of zero behave as one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r <= {2'b00, GMT_DISP_RATE_RST, 2'b00, GMT_ANA_RATE_RST};
    end else if (bus_wr && avs_address_i == GMT_REG_CTRL) begin
      ctrl_r <= ((ctrl_r & ~wmask) | (avs_writedata_i & wmask)) & 32'hBFFF_3FFF;
    end
  end

  // Interrupt status: a new event wins over a same-cycle clear
  assign ev[GMT_EV_START] = win_start;
  assign ev[GMT_EV_STOP] = win_stop;
  assign ev[GMT_EV_RANGE] = in_window && tick && sample_over_range_i;
  assign ev[GMT_EV_NORMAL] = (mode_r == GMT_READOUT) && readout_if.done && !win_start;
  assign irq_clr = (bus_wr && avs_address_i == GMT_REG_IRQ_STS && avs_byteenable_i[0]) ?
                   avs_writedata_i[GMT_EV_W-1:0] : '0;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_sts_r <= '0;
    end else begin
      irq_sts_r <= (irq_sts_r & ~irq_clr) | ev;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_mask_r <= '0;
    end else if (bus_wr && avs_address_i == GMT_REG_IRQ_MASK && avs_byteenable_i[0]) begin
      irq_mask_r <= avs_writedata_i[GMT_EV_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_sts_r & irq_mask_r);
    end
  end

endmodule // gmt_totalizer
`default_nettype wire

/* File: verification/gated_mass_totalizer_tb.sv */
/*
  Self-checking bench of the gated mass totalizer.
  Assumes the gate partner and the checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module gated_mass_totalizer_tb;
  import gmt_pkg::*;
  localparam int MSC = 10;
  localparam int RDO = 5;
  localparam int HLD = 15;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  wire logic gate;
  logic [15:0] flow = 16'h1234;
  // Nine-bit increments let a window of legal length reach saturation
  localparam int INCW = 9;
  logic [INCW-1:0] grams = 9'h000;
  logic [INCW-1:0] nlit = 9'h000;
  logic over = 1'b0;
  logic [14:0] pdata;
  logic prdy, lamp, blank, irq, wreq;
  logic [19:0] disp;
  logic [15:0] ana;
  logic [2:0] adr = 3'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] rv;
  int err_count = 0;
  int num_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  gmt_gate_ctl u_gate (.core_clk_i(core_clk_i), .gate_o(gate));
  gmt_totalizer #(.MS_CYCLES(MSC), .READOUT_MS(RDO), .HOLD_MS(HLD), .INC_W(INCW)) DUT (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .remote_gate_i(gate), .sample_flow_i(flow),
    .sample_grams_i(grams), .sample_nliters_i(nlit), .sample_over_range_i(over),
    .par_data_o(pdata), .par_ready_o(prdy), .gate_active_lamp_o(lamp), .display_blank_o(blank),
    .display_value_o(disp), .analog_value_o(ana), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .irq_o(irq));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("[ERR] %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One Avalon cycle; holds the request until waitrequest is seen low
  task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_i);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    // A slave that never answers is caught by the watchdog
    do begin
      @(posedge core_clk_i);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wt(input int t);
    repeat (t * MSC) @(posedge core_clk_i);
  endtask
  task automatic win(input int t);
    u_gate.run_window(t * MSC);
    repeat (3) @(posedge core_clk_i);
  endtask
  task automatic t_regs;
    chk("lamp", ZERO, 32'(lamp));
    chk("ready", ZERO, 32'(prdy));
    bus(GMT_REG_CTRL, 1'b0, ZERO, rv);
    chk("ctrl", 32'h0064_0001, rv);
    bus(3'h6, 1'b0, ZERO, rv);
    chk("unmapped", ZERO, rv);
    bus(GMT_REG_RESULT, 1'b1, 32'h0000_7FFF, rv);
    bus(GMT_REG_RESULT, 1'b0, ZERO, rv);
    chk("result_ro", ZERO, rv);
    bus(GMT_REG_CTRL, 1'b1, 32'h0001_0064, rv);
    bus(GMT_REG_IRQ_MASK, 1'b1, 32'h0000_0008, rv);
  endtask
  // Slow analog rate outside the window shows the window forces every tick
  task automatic t_basic;
    grams <= 9'h003;
    fork
      u_gate.run_window(10 * MSC);
      begin
        wt(3);
        flow <= 16'h4321;
        wt(3);
        chk("analog", 32'h0000_4321, 32'(ana));
        chk("lamp", ONE, 32'(lamp));
        chk("blank", ONE, 32'(blank));
      end
    join
    repeat (3) @(posedge core_clk_i);
    chk_rng("total", 32'h0000_001B, 32'h0000_001E, 32'(pdata));
    chk("ready", ONE, 32'(prdy));
    chk("irq_masked", ZERO, 32'(irq));
    bus(GMT_REG_RESULT, 1'b0, ZERO, rv);
    chk_rng("result", 32'h0000_001B, 32'h0000_001E, rv);
    wt(RDO + 2);
    bus(GMT_REG_STATUS, 1'b0, ZERO, rv);
    chk("readout", ZERO, rv & 32'h0000_0002);
    chk("ready_kept", ONE, 32'(prdy));
    chk("irq", ONE, 32'(irq));
    bus(GMT_REG_IRQ_STS, 1'b0, ZERO, rv);
    chk("irq_sts", 32'h0000_000B, rv);
    bus(GMT_REG_FLOW, 1'b0, ZERO, rv);
    chk("flow_reg", 32'h0000_4321, rv);
    bus(GMT_REG_IRQ_STS, 1'b1, 32'h0000_000F, rv);
    repeat (3) @(posedge core_clk_i);
    chk("irq_clr", ZERO, 32'(irq));
    wt(HLD);
    chk("ready_off", ZERO, 32'(prdy));
  endtask
  task automatic t_over;
    grams <= 9'h001;
    fork
      u_gate.run_window(10 * MSC);
      begin
        wt(4);
        over <= 1'b1;
        wt(2);
        over <= 1'b0;
      end
    join
    repeat (3) @(posedge core_clk_i);
    chk("over_data", 32'h0000_7FFF, 32'(pdata));
    chk("over_ready", ONE, 32'(prdy));
    chk("marker", 32'h000F_423F, 32'(disp));
    wt(RDO + 2);
    chk("display", 32'h0000_4321, 32'(disp));
    wt(HLD);
  endtask
  task automatic t_unit;
    bus(GMT_REG_CTRL, 1'b1, 32'h8001_0064, rv);
    nlit <= 9'h005;
    win(10);
    chk_rng("liters", 32'h0000_002D, 32'h0000_0032, 32'(pdata));
    bus(GMT_REG_CTRL, 1'b1, 32'h0001_0064, rv);
    // No wait here: the next window opens during this readout
  endtask
  task automatic t_sat;
    grams <= 9'h1FF;
    win(115);
    chk("saturate", 32'h0000_7FFF, 32'(pdata));
    chk("sat_disp", 32'h0000_7FFF, 32'(disp));
    wt(RDO + HLD);
  endtask
  initial begin
    #100_000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_regs;
    t_basic;
    t_over;
    t_unit;
    t_sat;
    tally_and_finish;
  end
endmodule // gated_mass_totalizer_tb
`default_nettype wire

/* File: verification/gmt_gate_ctl.sv */
/*
  Gate partner: the remote controller that opens and closes windows.
  Assumes the caller runs one window at a time on core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module gmt_gate_ctl (
  // Clock
  input wire logic core_clk_i,
  // Gate line, idle high
  output logic gate_o
);
  initial gate_o = 1'b1;
  // Window length is scaled down with the tick period
  task automatic run_window(input int cycles);
    @(posedge core_clk_i);
    gate_o <= 1'b0;
    repeat (cycles) @(posedge core_clk_i);
    gate_o <= 1'b1;
  endtask
endmodule // gmt_gate_ctl
`default_nettype wire

/* File: verification/gmt_totalizer_props.sv */
/*
  Port-level checker of the gated mass totalizer.
  Assumes it is bound to gmt_totalizer and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module gmt_totalizer_props
  import gmt_pkg::*;
#(
  parameter int MS_CYCLES = GMT_MS_CYCLES,
  parameter int HOLD_MS = GMT_HOLD_MS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Gate and results
  input wire logic remote_gate_i,
  input wire logic [GMT_TOTAL_W-1:0] par_data_o,
  input wire logic par_ready_o,
  input wire logic gate_active_lamp_o,
  input wire logic display_blank_o,
  input wire logic [19:0] display_value_o,
  // Bus
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o
);
  localparam int HOLD_LO = (HOLD_MS - 1) * MS_CYCLES;
  localparam int HOLD_HI = (HOLD_MS + 1) * MS_CYCLES;
  logic [31:0] hold_cnt_r;
  // Run length of the ready flag, judged when it drops; wide enough for full-length holds
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !par_ready_o) hold_cnt_r <= 32'h0000_0000;
    else hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_open_lamp: assert property ($fell(remote_gate_i) && !gate_active_lamp_o |=> gate_active_lamp_o && !par_ready_o)
    else $error("window did not open on gate fall");
  a_close_ready: assert property ($rose(remote_gate_i) && gate_active_lamp_o |=> !gate_active_lamp_o && par_ready_o)
    else $error("window did not close on gate rise");
  a_lamp_blank: assert property (gate_active_lamp_o == display_blank_o)
    else $error("blanking differs from lamp");
  a_marker_full: assert property (display_value_o == GMT_DISP_OVER |-> par_data_o == GMT_TOTAL_MAX)
    else $error("marker shown without all-ones result");
  a_ready_hold: assert property ($fell(par_ready_o) && !gate_active_lamp_o
    |-> hold_cnt_r >= HOLD_LO && hold_cnt_r <= HOLD_HI)
    else $error("ready held for wrong time");
  a_data_stable: assert property (par_ready_o && $past(par_ready_o) |-> $stable(par_data_o))
    else $error("result moved while ready");
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus not answered after one wait cycle");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_result_read: assert property (!avs_waitrequest_o && $past(avs_read_i)
    && $past(avs_address_i) == GMT_REG_RESULT |-> avs_readdata_o == {17'h0_0000, par_data_o})
    else $error("bus result differs from parallel result");
  a_unmapped_zero: assert property (!avs_waitrequest_o && $past(avs_read_i) && $past(avs_address_i) > 3'h5
    |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  c_ready: cover property ($rose(par_ready_o));
  c_marker: cover property (display_value_o == GMT_DISP_OVER);
  c_close: cover property ($fell(gate_active_lamp_o));
endmodule // gmt_totalizer_props
bind gmt_totalizer gmt_totalizer_props #(.MS_CYCLES(MS_CYCLES), .HOLD_MS(HOLD_MS)) u_props (
  .core_clk_i, .rst_i, .remote_gate_i, .par_data_o, .par_ready_o, .gate_active_lamp_o, .display_blank_o,
  .display_value_o, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o);
`default_nettype wire
